//--- verilog/wdc_watchdog.v
// Implementation choices: the register addresses and the APB interface to the registers.
`include "wdc_regs.vh"

// What this block does
// [R1] Counter drops by one every 16384 clock cycles.
// [R2] Six low counter bits set the timeout in 64 steps.
// [R3] Active watchdog resets when counter passes 40h to 3Fh.
// [R4] Watchdog reset drives reset pin low for about 30 us.
// [R5] Counter keeps counting even when not activated.
// [R6] Software rewrites control register before the top bit clears.
// [R7] Software writes values between FFh and C0h.
// [R8] Control writes never realign the prescaler.
// [R9] After reset the watchdog is inactive; reset clears hardware mode as well.
// [R10] Software cannot clear the activation bit; only reset does.
// [R11] Writing activation set with top bit clear resets immediately.
// [R12] Halt instruction while active resets instead of halting, per option.
// [R13] An option decides whether halt triggers a watchdog reset.
// [R14] An option selects hardware watchdog mode, always active.
// [R15] Software should always write one into the counter top bit.
// [R16] Control register resets to 7Fh.
// [R17] In hardware mode the activation bit has no effect.
// [R18] A write loads all seven counter bits at once; decrement at next terminal count.
// [R19] Prescaler free-runs, cleared only by reset, one strobe per terminal count.
module wdc_watchdog (
	// Clock and reset.
	input  wire        clk,
	input  wire        rst_n,
	// APB slave.
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire [31:0] prdata,
	output wire        pslverr,
	// Processor side.
	input  wire        haltExec,
	output reg         haltEnter,
	// Reset pin.
	output reg         resetPinOut,
	output reg         resetPinOe_n,
	output reg         wdgResetReq
);

	// One-hot states of the reset pulse generator.
	localparam ST_IDLE  = 2'b01;
	localparam ST_PULSE = 2'b10;

	// Terminal counts and the control reset value.
	localparam [13:0] PRESC_LAST = `WDC_PRESC_LAST;
	localparam [11:0] PULSE_LAST = `WDC_PULSE_LAST;
	localparam [7:0]  CTRL_RESET = `WDC_CTRL_RESET;

	// Registered state.
	reg  [13:0] presc;
	reg  [6:0]  count;
	reg         actBit;
	reg         hwWatchdog;
	reg         haltResetOption;
	reg         wdgResetSeen;
	reg  [1:0]  state;
	reg  [11:0] pulseCnt;
	reg  [31:0] readData;

	// Next values, all worked out combinationally.
	reg  [13:0] next_presc;
	reg  [6:0]  next_count;
	reg         next_actBit;
	reg         next_hwWatchdog;
	reg         next_haltResetOption;
	reg         next_wdgResetSeen;
	reg  [1:0]  next_state;
	reg  [11:0] next_pulseCnt;
	reg         next_resetPinOut;
	reg         next_resetPinOe_n;
	reg         next_wdgResetReq;
	reg         next_haltEnter;
	reg  [31:0] next_readData;

	// Bus decode.
	wire        access;
	wire        ctrlSel;
	wire        optSel;
	wire        statSel;
	wire        ctrlWrite;
	wire        optWrite;
	wire        readSetup;
	wire [7:0]  ctrlView;
	wire [1:0]  optView;
	wire [2:0]  statView;

	// Watchdog conditions.
	wire        decStrobe;
	wire        active;
	wire        rollover;
	wire        softReset;
	wire        haltReset;
	wire        fire;
	wire        pulseDone;

	function isAddr;
		input [11:0] addr;
		input [11:0] offset;
		begin
			isAddr = (addr == offset);
		end
	endfunction

	// The slave answers in the first access cycle; there are no wait states.
	assign access    = psel & penable;
	assign ctrlSel   = isAddr(paddr, `WDC_CTRL_OFFSET);
	assign optSel    = isAddr(paddr, `WDC_OPT_OFFSET);
	// Status is read-only; a write to it is accepted and has no effect.
	assign statSel   = isAddr(paddr, `WDC_STAT_OFFSET);
	assign pready    = 1'b1;
	// Unmapped offsets answer with an error, and writes to them are dropped.
	assign pslverr   = access & ~(ctrlSel | optSel | statSel);
	assign ctrlWrite = access & pwrite & ctrlSel;
	assign optWrite  = access & pwrite & optSel;
	assign readSetup = psel & ~penable & ~pwrite;
	assign prdata    = readData;

	// Register images as software reads them; unused bits read as zero.
	assign ctrlView  = {actBit, count};
	assign optView   = {haltResetOption, hwWatchdog};
	assign statView  = {wdgResetSeen, wdgResetReq, active};

	// The strobe marks the prescaler's terminal count, one per period.
	assign decStrobe = (presc == PRESC_LAST); // [R19]
	assign active    = actBit | hwWatchdog; // [R17]
	// A write in the strobe cycle wins, so the old count cannot also roll over.
	assign rollover  = decStrobe & (count == 7'h40) & ~ctrlWrite; // [R3]
	// Immediate reset when software activates with the top bit clear.
	// In hardware mode the activation bit does not matter, so any such write fires.
	assign softReset = ctrlWrite & (pwdata[`WDC_ACT_BIT] | hwWatchdog | actBit) &
		~pwdata[`WDC_TOP_BIT]; // [R11]
	assign haltReset = haltExec & active & haltResetOption; // [R12]
	assign fire      = (active & rollover) | softReset | haltReset; // [R3]
	assign pulseDone = (pulseCnt == PULSE_LAST); // [R4]

	// Prescaler is never touched by a write, so timeout jitters by one period.
	always @* begin
		if (decStrobe) begin
			next_presc = 14'h0000; // [R19]
		end else begin
			next_presc = presc + 14'h0001; // [R8]
		end
	end

	// A write loads the count directly; otherwise it drops on each strobe.
	always @* begin
		next_count = count;
		if (ctrlWrite) begin
			next_count = pwdata[6:0]; // [R18] [R2]
		end else if (decStrobe) begin
			next_count = count - 7'h01; // [R1] [R5]
		end
	end

	// Activation can only be set by a write; reset alone clears it.
	always @* begin
		next_actBit = actBit;
		if (ctrlWrite && pwdata[`WDC_ACT_BIT]) begin
			next_actBit = 1'b1; // [R10]
		end
	end

	// Hardware mode, once set, survives until reset like a fuse; the halt option reloads on every write.
	always @* begin
		next_hwWatchdog      = hwWatchdog;
		next_haltResetOption = haltResetOption;
		if (optWrite) begin
			next_hwWatchdog      = hwWatchdog | pwdata[`WDC_OPT_HWWD_BIT]; // [R14]
			next_haltResetOption = pwdata[`WDC_OPT_HALT_BIT]; // [R13]
		end
	end

	// The processor halts only when the halt does not turn into a reset.
	always @* begin
		next_haltEnter = haltExec & ~haltReset; // [R12]
	end

	// Reset pulse generator on an open-drain pin; a new cause during a pulse is dropped.
	always @* begin
		next_state        = state;
		next_pulseCnt     = pulseCnt;
		next_resetPinOut  = resetPinOut;
		next_resetPinOe_n = resetPinOe_n;
		next_wdgResetReq  = wdgResetReq;
		next_wdgResetSeen = wdgResetSeen;
		case (state)
			ST_IDLE: begin
				if (fire) begin
					next_state        = ST_PULSE;
					next_pulseCnt     = 12'h000;
					next_resetPinOut  = 1'b0; // [R4]
					next_resetPinOe_n = 1'b0;
					next_wdgResetReq  = 1'b1;
					next_wdgResetSeen = 1'b1;
				end
			end
			ST_PULSE: begin
				if (pulseDone) begin
					next_state        = ST_IDLE;
					next_resetPinOut  = 1'b1;
					next_resetPinOe_n = 1'b1;
					next_wdgResetReq  = 1'b0;
				end else begin
					next_pulseCnt = pulseCnt + 12'h001; // [R4]
				end
			end
			default: begin
				// An illegal state code returns to idle with the pin released.
				next_state        = ST_IDLE;
				next_pulseCnt     = 12'h000;
				next_resetPinOut  = 1'b1;
				next_resetPinOe_n = 1'b1;
				next_wdgResetReq  = 1'b0;
			end
		endcase
	end

	// Read data is captured in the setup cycle so it stands through the access.
	always @* begin
		next_readData = readData;
		if (readSetup) begin
			next_readData = 32'h00000000;
			if (ctrlSel) begin
				next_readData[7:0] = ctrlView;
			end else if (optSel) begin
				next_readData[1:0] = optView;
			end else if (statSel) begin
				next_readData[2:0] = statView;
			end
		end
	end

	// All state below loads its next value on every edge; reset loads constants only.
	// The prescaler clears only on reset, never on a write.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presc <= 14'h0000;
		end else begin
			presc <= next_presc; // [R19]
		end
	end

	// Control register comes out of reset at 7Fh, watchdog off.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count  <= CTRL_RESET[6:0]; // [R16]
			actBit <= CTRL_RESET[7]; // [R9]
		end else begin
			count  <= next_count;
			actBit <= next_actBit;
		end
	end

	// Options come out of reset cleared.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hwWatchdog      <= 1'b0;
			haltResetOption <= 1'b0;
		end else begin
			hwWatchdog      <= next_hwWatchdog;
			haltResetOption <= next_haltResetOption;
		end
	end

	// Halt entry never shows while reset is held.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			haltEnter <= 1'b0;
		end else begin
			haltEnter <= next_haltEnter;
		end
	end

	// The pin is released and no pulse is in progress after reset.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state        <= ST_IDLE;
			pulseCnt     <= 12'h000;
			resetPinOut  <= 1'b1;
			resetPinOe_n <= 1'b1;
			wdgResetReq  <= 1'b0;
			wdgResetSeen <= 1'b0;
		end else begin
			state        <= next_state;
			pulseCnt     <= next_pulseCnt;
			resetPinOut  <= next_resetPinOut;
			resetPinOe_n <= next_resetPinOe_n;
			wdgResetReq  <= next_wdgResetReq;
			wdgResetSeen <= next_wdgResetSeen;
		end
	end

	// Read data holds between reads.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readData <= 32'h00000000;
		end else begin
			readData <= next_readData;
		end
	end

endmodule // wdc_watchdog

//--- pkg/wdc_regs.vh
`ifndef WDC_REGS_VH
`define WDC_REGS_VH

// Register byte offsets.
`define WDC_CTRL_OFFSET     12'h000
`define WDC_OPT_OFFSET      12'h004
`define WDC_STAT_OFFSET     12'h008

// Control register fields.
`define WDC_ACT_BIT         7
`define WDC_TOP_BIT         6
`define WDC_CTRL_RESET      8'h7F

// Option register fields, standing in for the non-volatile option byte.
`define WDC_OPT_HWWD_BIT    0
`define WDC_OPT_HALT_BIT    1

// Timing.
`define WDC_PRESC_CYCLES    16384
`define WDC_PULSE_NS        30000
`define WDC_CLK_NS          10
`define WDC_PULSE_CYCLES    ((`WDC_PULSE_NS + `WDC_CLK_NS - 1) / `WDC_CLK_NS)
`define WDC_PRESC_LAST      14'h3FFF
`define WDC_PULSE_LAST      12'hBB7

`endif

//--- dv/wdc_watchdog_assertions.sv
module wdc_watchdog_checker (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        rst_n,
	// APB, observed only.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Processor side and reset pin.
	input wire logic        haltExec,
	input wire logic        haltEnter,
	input wire logic        resetPinOut,
	input wire logic        resetPinOe_n,
	input wire logic        wdgResetReq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] len;
	// Counting the pulse avoids an unrollable 3000-deep repetition.
	always @(posedge clk or negedge rst_n)
		if (!rst_n) len <= 12'h000;
		else len <= wdgResetReq ? len + 12'h001 : 12'h000;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_sw;
		psel && penable && pwrite && paddr == 12'h000 && pwdata[7:6] == 2'b10 |=> wdgResetReq;
	endproperty
	a_sw: assert property (p_sw) else $error("software trigger ignored");
	property p_len; $fell(wdgResetReq) |-> len == 12'hBB8; endproperty
	a_len: assert property (p_len) else $error("pulse length off");
	property p_stay; $rose(wdgResetReq) |=> wdgResetReq [*8]; endproperty
	a_stay: assert property (p_stay) else $error("pulse too short");
	property p_oe; resetPinOe_n == !wdgResetReq; endproperty
	a_oe: assert property (p_oe) else $error("enable and request disagree");
	property p_pin; resetPinOut == resetPinOe_n; endproperty
	a_pin: assert property (p_pin) else $error("pin level wrong");
	property p_halt; $rose(haltEnter) |-> $past(haltExec); endproperty
	a_halt: assert property (p_halt) else $error("halt entry without cause");
	property p_err; psel && penable && paddr == 12'h010 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access accepted");
	property p_rdy; psel && penable |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("wait state seen");
endmodule // wdc_watchdog_checker

//--- dv/wdc_tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, haltExec = 0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	wire         pready, pslverr, haltEnter, resetPinOut, resetPinOe_n, wdgResetReq;
	wire  [31:0] prdata;
	int          mismatches = 0, samples_checked = 0;
	always #5 clk = ~clk;
	wdc_watchdog i_dut (
		.clk          (clk),
		.rst_n        (rst_n),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.pready       (pready),
		.prdata       (prdata),
		.pslverr      (pslverr),
		.haltExec     (haltExec),
		.haltEnter    (haltEnter),
		.resetPinOut  (resetPinOut),
		.resetPinOe_n (resetPinOe_n),
		.wdgResetReq  (wdgResetReq)
	);
	task rs;
		rst_n <= 0;
		repeat (6) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
	endtask
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1;
		do @(posedge clk); while (pready !== 1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task chk(input logic [31:0] s, x);
		samples_checked++;
		if (s !== x) begin
			mismatches++;
			$display("wrong value at %0t: %h not %h", $time, s, x);
		end
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] x);
		acc(0, a, 32'h0);
		chk(rd, x);
	endtask
	task wq(input logic v, input int m);
		repeat (m) begin
			@(posedge clk);
			if (wdgResetReq === v) break;
		end
		chk(wdgResetReq, v);
	endtask
	task hlt;
		haltExec <= 1;
		@(posedge clk) haltExec <= 0;
	endtask
	task results;
		$display("checked %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#500us;
		mismatches++;
		results;
	end
	initial begin
		rs;
		rdc(12'h000, 32'h7F);
		rdc(12'h008, 32'h0);
		acc(1, 12'h000, 32'h3F);
		wq(0, 2);
		acc(1, 12'h000, 32'hFF);
		acc(1, 12'h000, 32'h7F);
		rdc(12'h000, 32'hFF);
		rdc(12'h010, 32'h0);
		chk(er, 1);
		acc(1, 12'h000, 32'hC0);
		wq(1, 16400);
		wq(0, 3100);
		rdc(12'h008, 32'h5);
		acc(1, 12'h000, 32'h80);
		wq(1, 2);
		$display("timeout test done");
		rs;
		acc(1, 12'h004, 32'h2);
		acc(1, 12'h000, 32'hFF);
		hlt;
		wq(1, 3);
		chk(haltEnter, 0);
		rs;
		acc(1, 12'h004, 32'h2);
		hlt;
		@(posedge clk);
		chk(haltEnter, 1);
		repeat (16400) @(posedge clk);
		rdc(12'h000, 32'h7E);
		$display("halt test done");
		rs;
		acc(1, 12'h004, 32'h1);
		acc(1, 12'h000, 32'h0);
		wq(1, 2);
		$display("hardware mode test done");
		results;
	end
endmodule // tb
bind wdc_watchdog wdc_watchdog_checker i_chk (
	.clk          (clk),
	.rst_n        (rst_n),
	.psel         (psel),
	.penable      (penable),
	.pwrite       (pwrite),
	.paddr        (paddr),
	.pwdata       (pwdata),
	.pready       (pready),
	.pslverr      (pslverr),
	.haltExec     (haltExec),
	.haltEnter    (haltEnter),
	.resetPinOut  (resetPinOut),
	.resetPinOe_n (resetPinOe_n),
	.wdgResetReq  (wdgResetReq)
);
